// ==== rtl/dubp_pkg.sv ====
package dubp_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int BUS_SYNC_W = 16;
  localparam int PIN_SYNC_W = 5;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [BUS_SYNC_W-1:0] BUS_SYNC_RST = 16'hffff;
  localparam logic [PIN_SYNC_W-1:0] PIN_SYNC_RST = 5'h1f;
  localparam logic                  TX_IDLE_STD  = 1'h1;
  localparam logic                  PIN_OFF_N    = 1'h1;
  localparam logic                  OE_OFF_N     = 1'h1;
  localparam logic [DATA_W-1:0]     DATA_RST     = 8'h00;
  localparam logic [ADDR_W-1:0]     ADDR_RST     = 3'h0;

  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic MODE_STROBE = 1'h1;
  localparam logic CHAN_A      = 1'h0;
  localparam logic CHAN_B      = 1'h1;
  localparam logic DIR_READ    = 1'h1;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_RD_WAIT  = 2'b01,
    ST_RD_DRIVE = 2'b10,
    ST_WR_HOLD  = 2'b11
  } dubp_bus_state_e;
endpackage

// ==== rtl/dubp_chan_if.sv ====
interface dubp_chan_if;
  logic irq_req;
  logic aux2_en;
  logic ir_mode;
  logic rx_inv;
  logic rts_on;
  logic auto_rts;
  logic rx_room;
  logic rs485_dir;
  logic tx_busy;
  logic auto_cts;
  logic dtr_on;
  logic tx_bit;
  logic tx_ir_bit;
  logic tx_rdy;
  logic rx_rdy;
  logic serial_in;
  logic cts_n;
  logic dsr_n;
  logic cd_n;
  logic ri_n;
  logic serial_out;
  logic rts_n;
  logic dtr_n;
  logic aux2_n;
  logic tx_rdy_n;
  logic rx_rdy_n;
  logic rx_data;
  logic cts_on;
  logic dsr_on;
  logic cd_on;
  logic ri_on;
  logic tx_allowed;

  modport chan (
    input  irq_req, aux2_en, ir_mode, rx_inv, rts_on, auto_rts, rx_room, rs485_dir, tx_busy,
    input  auto_cts, dtr_on, tx_bit, tx_ir_bit, tx_rdy, rx_rdy,
    input  serial_in, cts_n, dsr_n, cd_n, ri_n,
    output serial_out, rts_n, dtr_n, aux2_n, tx_rdy_n, rx_rdy_n,
    output rx_data, cts_on, dsr_on, cd_on, ri_on, tx_allowed
  );
  modport top (
    output irq_req, aux2_en, ir_mode, rx_inv, rts_on, auto_rts, rx_room, rs485_dir, tx_busy,
    output auto_cts, dtr_on, tx_bit, tx_ir_bit, tx_rdy, rx_rdy,
    output serial_in, cts_n, dsr_n, cd_n, ri_n,
    input  serial_out, rts_n, dtr_n, aux2_n, tx_rdy_n, rx_rdy_n,
    input  rx_data, cts_on, dsr_on, cd_on, ri_on, tx_allowed
  );
endinterface

// ==== rtl/dubp_chan_pins.sv ====
module dubp_chan_pins (
  input wire logic   clk_sys,
  input wire logic   rstn,
  dubp_chan_if.chan  ch
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [dubp_pkg::PIN_SYNC_W-1:0] meta;
  logic [dubp_pkg::PIN_SYNC_W-1:0] sync;
  logic                            s_rx;
  logic                            s_cts;
  logic                            s_dsr;
  logic                            s_cd;
  logic                            s_ri;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta <= dubp_pkg::PIN_SYNC_RST;
      sync <= dubp_pkg::PIN_SYNC_RST;
    end else begin
      meta <= {ch.serial_in, ch.cts_n, ch.dsr_n, ch.cd_n, ch.ri_n};
      sync <= meta;
    end
  end

  assign {s_rx, s_cts, s_dsr, s_cd, s_ri} = sync;

  // ---------------------------------------------------------------
  // Serial data
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ch.serial_out <= dubp_pkg::TX_IDLE_STD;
      ch.rx_data    <= dubp_pkg::TX_IDLE_STD;
    end else if (ch.ir_mode) begin
      ch.serial_out <= ch.tx_ir_bit;
      ch.rx_data    <= s_rx ^ ch.rx_inv;
    end else begin
      ch.serial_out <= ch.tx_bit;
      ch.rx_data    <= s_rx;
    end
  end

  // ---------------------------------------------------------------
  // Modem outputs
  // ---------------------------------------------------------------
  // Half-duplex direction wins over software RTS so the line driver follows the transmitter
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ch.rts_n <= dubp_pkg::PIN_OFF_N;
    end else if (ch.rs485_dir) begin
      ch.rts_n <= ~ch.tx_busy;
    end else if (ch.auto_rts) begin
      ch.rts_n <= ~(ch.rts_on & ch.rx_room);
    end else begin
      ch.rts_n <= ~ch.rts_on;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ch.dtr_n    <= dubp_pkg::PIN_OFF_N;
      ch.aux2_n   <= dubp_pkg::PIN_OFF_N;
      ch.tx_rdy_n <= dubp_pkg::PIN_OFF_N;
      ch.rx_rdy_n <= dubp_pkg::PIN_OFF_N;
    end else begin
      ch.dtr_n    <= ~ch.dtr_on;
      ch.aux2_n   <= ~ch.aux2_en;
      ch.tx_rdy_n <= ~ch.tx_rdy;
      ch.rx_rdy_n <= ~ch.rx_rdy;
    end
  end

  // ---------------------------------------------------------------
  // Modem inputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ch.cts_on     <= 1'h0;
      ch.dsr_on     <= 1'h0;
      ch.cd_on      <= 1'h0;
      ch.ri_on      <= 1'h0;
      ch.tx_allowed <= 1'h0;
    end else begin
      ch.cts_on     <= ~s_cts;
      ch.dsr_on     <= ~s_dsr;
      ch.cd_on      <= ~s_cd;
      ch.ri_on      <= ~s_ri;
      ch.tx_allowed <= ~ch.auto_cts | ~s_cts;
    end
  end
endmodule

// ==== rtl/dubp_host_port.sv ====
// What this block does
// - Bus style pin high selects strobe mode, low selects read/write-line mode.
// - Strobe mode read strobe fall reads addressed register; byte driven until strobe rises.
// - Read/write-line mode ignores the read strobe pin.
// - Strobe mode write strobe rise stores bus byte into addressed register.
// - Read/write-line mode: write strobe pin high means read, low means write.
// - Strobe mode: two active-low chip selects pick channel A or B.
// - Read/write-line mode: one device select; second pin is channel bit, 0=A.
// - Strobe mode: bit 3 set drives irq with the channel's request and aux2 low; clear floats irq.
// - Read/write-line mode: channel A irq is shared open-drain active-low interrupt.
// - Read/write-line mode: channel B irq pin unused.
// - Each channel gives active-low transmit-ready and receive-ready outputs.
// - Bit 6 clear: standard serial, transmit held high in reset and idle.
// - Bit 6 set: infrared coding, transmit idles low.
// - CTS is a general input or gates transmit under auto CTS.
// - Each channel drives active-low DTR, usable as general output.
// - DSR, carrier detect, ring inputs are active-low, usable as general inputs.
// - Three address lines select a register of the addressed channel.
// - Host data bus is eight bits, bidirectional.
module dubp_host_port (
  input  wire logic                         clk_sys,
  input  wire logic                         rstn,
  input  wire logic                         bus_style_sel,
  input  wire logic                         read_strobe_n,
  input  wire logic                         write_strobe_n,
  input  wire logic                         chan_a_select_n,
  input  wire logic                         chan_b_select_n,
  input  wire logic [dubp_pkg::ADDR_W-1:0]  addr,
  input  wire logic [dubp_pkg::DATA_W-1:0]  data_in,
  output logic      [dubp_pkg::DATA_W-1:0]  data_out,
  output logic                              data_oe_n,
  output logic                              chan_a_irq,
  output logic                              chan_a_irq_oe_n,
  output logic                              chan_b_irq,
  output logic                              chan_b_irq_oe_n,
  output logic                              aux_out2_chan_a_n,
  output logic                              aux_out2_chan_b_n,
  output logic                              tx_ready_chan_a_n,
  output logic                              rx_ready_chan_a_n,
  output logic                              tx_ready_chan_b_n,
  output logic                              rx_ready_chan_b_n,
  output logic                              serial_out_chan_a,
  output logic                              serial_out_chan_b,
  input  wire logic                         serial_in_chan_a,
  input  wire logic                         serial_in_chan_b,
  output logic                              request_to_send_a_n,
  output logic                              request_to_send_b_n,
  input  wire logic                         clear_to_send_a_n,
  input  wire logic                         clear_to_send_b_n,
  output logic                              terminal_ready_a_n,
  output logic                              terminal_ready_b_n,
  input  wire logic                         set_ready_a_n,
  input  wire logic                         set_ready_b_n,
  input  wire logic                         carrier_detect_a_n,
  input  wire logic                         carrier_detect_b_n,
  input  wire logic                         ring_indicator_a_n,
  input  wire logic                         ring_indicator_b_n,
  output logic                              reg_rd,
  output logic                              reg_wr,
  output logic                              reg_chan,
  output logic      [dubp_pkg::ADDR_W-1:0]  reg_addr,
  output logic      [dubp_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic [dubp_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic [1:0]                   irq_req,
  input  wire logic [1:0]                   aux2_en,
  input  wire logic [1:0]                   ir_mode,
  input  wire logic [1:0]                   rx_invert,
  input  wire logic [1:0]                   rts_on,
  input  wire logic [1:0]                   auto_rts,
  input  wire logic [1:0]                   rx_room,
  input  wire logic [1:0]                   rs485_dir,
  input  wire logic [1:0]                   tx_busy,
  input  wire logic [1:0]                   auto_cts,
  input  wire logic [1:0]                   dtr_on,
  input  wire logic [1:0]                   tx_bit,
  input  wire logic [1:0]                   tx_ir_bit,
  input  wire logic [1:0]                   tx_fifo_ready,
  input  wire logic [1:0]                   rx_fifo_ready,
  output logic      [1:0]                   rx_data,
  output logic      [1:0]                   cts_on,
  output logic      [1:0]                   dsr_on,
  output logic      [1:0]                   cd_on,
  output logic      [1:0]                   ri_on,
  output logic      [1:0]                   tx_allowed
);
  // ---------------------------------------------------------------
  // Host pin synchronisers
  // ---------------------------------------------------------------
  logic [dubp_pkg::BUS_SYNC_W-1:0] bus_meta;
  logic [dubp_pkg::BUS_SYNC_W-1:0] bus_sync;
  logic                            s_mode;
  logic                            s_rd_n;
  logic                            s_wr_n;
  logic                            s_csa_n;
  logic                            s_csb_n;
  logic [dubp_pkg::ADDR_W-1:0]     s_addr;
  logic [dubp_pkg::DATA_W-1:0]     s_data;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bus_meta <= dubp_pkg::BUS_SYNC_RST;
      bus_sync <= dubp_pkg::BUS_SYNC_RST;
    end else begin
      bus_meta <= {bus_style_sel, read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n, addr, data_in};
      bus_sync <= bus_meta;
    end
  end

  assign {s_mode, s_rd_n, s_wr_n, s_csa_n, s_csb_n, s_addr, s_data} = bus_sync;

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  logic strobe_mode;
  logic one_select;
  logic acc_chan;
  logic acc_active;
  logic acc_read;
  logic acc_prev;
  logic acc_start;

  assign strobe_mode = (s_mode == dubp_pkg::MODE_STROBE);
  // In strobe mode both selects low is ambiguous, so such a cycle is ignored
  assign one_select  = s_csa_n ^ s_csb_n;

  always_comb begin
    if (strobe_mode) begin
      acc_chan   = s_csa_n ? dubp_pkg::CHAN_B : dubp_pkg::CHAN_A;
      acc_active = one_select & (~s_rd_n | ~s_wr_n);
      acc_read   = ~s_rd_n;
    end else begin
      acc_chan   = s_csb_n;
      acc_active = ~s_csa_n;
      acc_read   = (s_wr_n == dubp_pkg::DIR_READ);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      acc_prev <= 1'h0;
    end else begin
      acc_prev <= acc_active;
    end
  end

  assign acc_start = acc_active & ~acc_prev;

  // ---------------------------------------------------------------
  // Bus cycle sequencer
  // ---------------------------------------------------------------
  dubp_pkg::dubp_bus_state_e state;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= dubp_pkg::ST_IDLE;
    end else begin
      unique case (state)
        dubp_pkg::ST_IDLE: begin
          if (acc_start) begin
            state <= acc_read ? dubp_pkg::ST_RD_WAIT : dubp_pkg::ST_WR_HOLD;
          end
        end
        dubp_pkg::ST_RD_WAIT: begin
          state <= dubp_pkg::ST_RD_DRIVE;
        end
        dubp_pkg::ST_RD_DRIVE: begin
          if (!acc_active) begin
            state <= dubp_pkg::ST_IDLE;
          end
        end
        dubp_pkg::ST_WR_HOLD: begin
          if (!acc_active) begin
            state <= dubp_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Channel and address are frozen at the start of the cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_chan <= dubp_pkg::CHAN_A;
      reg_addr <= dubp_pkg::ADDR_RST;
    end else if (state == dubp_pkg::ST_IDLE && acc_start) begin
      reg_chan <= acc_chan;
      reg_addr <= s_addr;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rd <= 1'h0;
    end else begin
      reg_rd <= (state == dubp_pkg::ST_IDLE) & acc_start & acc_read;
    end
  end

  // Write data follows the bus until the strobe ends, then the last sample is stored
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_wdata <= dubp_pkg::DATA_RST;
    end else if (acc_active) begin
      reg_wdata <= s_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_wr <= 1'h0;
    end else begin
      reg_wr <= (state == dubp_pkg::ST_WR_HOLD) & ~acc_active;
    end
  end

  // ---------------------------------------------------------------
  // Data bus drive
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      data_out <= dubp_pkg::DATA_RST;
    end else if (state == dubp_pkg::ST_RD_WAIT) begin
      data_out <= reg_rdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      data_oe_n <= dubp_pkg::OE_OFF_N;
    end else if (state == dubp_pkg::ST_RD_WAIT) begin
      data_oe_n <= 1'h0;
    end else if (state == dubp_pkg::ST_RD_DRIVE && !acc_active) begin
      data_oe_n <= dubp_pkg::OE_OFF_N;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt pins
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      chan_a_irq      <= 1'h0;
      chan_a_irq_oe_n <= dubp_pkg::OE_OFF_N;
      chan_b_irq      <= 1'h0;
      chan_b_irq_oe_n <= dubp_pkg::OE_OFF_N;
    end else if (strobe_mode) begin
      chan_a_irq      <= irq_req[0];
      chan_a_irq_oe_n <= ~aux2_en[0];
      chan_b_irq      <= irq_req[1];
      chan_b_irq_oe_n <= ~aux2_en[1];
    end else begin
      // Open drain: only ever pulls low, the board pull-up gives the high
      chan_a_irq      <= 1'h0;
      chan_a_irq_oe_n <= ~(irq_req[0] | irq_req[1]);
      chan_b_irq      <= 1'h0;
      chan_b_irq_oe_n <= dubp_pkg::OE_OFF_N;
    end
  end

  // ---------------------------------------------------------------
  // Channel pin handlers
  // ---------------------------------------------------------------
  dubp_chan_if ch_if[2] ();

  logic [1:0] pin_serial_in;
  logic [1:0] pin_cts_n;
  logic [1:0] pin_dsr_n;
  logic [1:0] pin_cd_n;
  logic [1:0] pin_ri_n;
  logic [1:0] q_serial_out;
  logic [1:0] q_rts_n;
  logic [1:0] q_dtr_n;
  logic [1:0] q_aux2_n;
  logic [1:0] q_tx_rdy_n;
  logic [1:0] q_rx_rdy_n;

  assign pin_serial_in = {serial_in_chan_b, serial_in_chan_a};
  assign pin_cts_n     = {clear_to_send_b_n, clear_to_send_a_n};
  assign pin_dsr_n     = {set_ready_b_n, set_ready_a_n};
  assign pin_cd_n      = {carrier_detect_b_n, carrier_detect_a_n};
  assign pin_ri_n      = {ring_indicator_b_n, ring_indicator_a_n};

  for (genvar g = 0; g < 2; g++) begin : g_chan
    assign ch_if[g].irq_req   = irq_req[g];
    assign ch_if[g].aux2_en   = aux2_en[g];
    assign ch_if[g].ir_mode   = ir_mode[g];
    assign ch_if[g].rx_inv    = rx_invert[g];
    assign ch_if[g].rts_on    = rts_on[g];
    assign ch_if[g].auto_rts  = auto_rts[g];
    assign ch_if[g].rx_room   = rx_room[g];
    assign ch_if[g].rs485_dir = rs485_dir[g];
    assign ch_if[g].tx_busy   = tx_busy[g];
    assign ch_if[g].auto_cts  = auto_cts[g];
    assign ch_if[g].dtr_on    = dtr_on[g];
    assign ch_if[g].tx_bit    = tx_bit[g];
    assign ch_if[g].tx_ir_bit = tx_ir_bit[g];
    assign ch_if[g].tx_rdy    = tx_fifo_ready[g];
    assign ch_if[g].rx_rdy    = rx_fifo_ready[g];
    assign ch_if[g].serial_in = pin_serial_in[g];
    assign ch_if[g].cts_n     = pin_cts_n[g];
    assign ch_if[g].dsr_n     = pin_dsr_n[g];
    assign ch_if[g].cd_n      = pin_cd_n[g];
    assign ch_if[g].ri_n      = pin_ri_n[g];

    assign q_serial_out[g] = ch_if[g].serial_out;
    assign q_rts_n[g]      = ch_if[g].rts_n;
    assign q_dtr_n[g]      = ch_if[g].dtr_n;
    assign q_aux2_n[g]     = ch_if[g].aux2_n;
    assign q_tx_rdy_n[g]   = ch_if[g].tx_rdy_n;
    assign q_rx_rdy_n[g]   = ch_if[g].rx_rdy_n;
    assign rx_data[g]      = ch_if[g].rx_data;
    assign cts_on[g]       = ch_if[g].cts_on;
    assign dsr_on[g]       = ch_if[g].dsr_on;
    assign cd_on[g]        = ch_if[g].cd_on;
    assign ri_on[g]        = ch_if[g].ri_on;
    assign tx_allowed[g]   = ch_if[g].tx_allowed;

    dubp_chan_pins u_pins (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .ch      (ch_if[g].chan)
    );
  end

  assign serial_out_chan_a   = q_serial_out[0];
  assign serial_out_chan_b   = q_serial_out[1];
  assign request_to_send_a_n = q_rts_n[0];
  assign request_to_send_b_n = q_rts_n[1];
  assign terminal_ready_a_n  = q_dtr_n[0];
  assign terminal_ready_b_n  = q_dtr_n[1];
  assign aux_out2_chan_a_n   = q_aux2_n[0];
  assign aux_out2_chan_b_n   = q_aux2_n[1];
  assign tx_ready_chan_a_n   = q_tx_rdy_n[0];
  assign tx_ready_chan_b_n   = q_tx_rdy_n[1];
  assign rx_ready_chan_a_n   = q_rx_rdy_n[0];
  assign rx_ready_chan_b_n   = q_rx_rdy_n[1];
endmodule

// ==== tb/dubp_host_port_chk.sv ====
module dubp_host_port_chk (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       bus_style_sel,
  input wire logic       reg_rd,
  input wire logic       reg_wr,
  input wire logic       data_oe_n,
  input wire logic [7:0] data_out,
  input wire logic       chan_a_irq,
  input wire logic       chan_a_irq_oe_n,
  input wire logic       chan_b_irq_oe_n,
  input wire logic [1:0] irq_req,
  input wire logic [1:0] aux2_en,
  input wire logic       serial_out_chan_a,
  input wire logic [1:0] ir_mode,
  input wire logic [1:0] tx_ir_bit,
  input wire logic [1:0] tx_bit,
  input wire logic       request_to_send_a_n,
  input wire logic [1:0] rs485_dir,
  input wire logic [1:0] tx_busy
);
  // ----------
  // Checks
  // ----------
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  sequence s_rd_drive;
    ##1 !reg_rd && !data_oe_n ##1 !data_oe_n;
  endsequence
  rd_drive_a: assert property (reg_rd |-> s_rd_drive)
    else $error("read not driven");
  drive_cause_a: assert property ($fell(data_oe_n) |-> $past(reg_rd))
    else $error("bus driven without read");
  data_hold_a: assert property (!data_oe_n && !$past(data_oe_n) |-> $stable(data_out))
    else $error("read data moved");
  wr_pulse_a: assert property (reg_wr |=> !reg_wr && data_oe_n)
    else $error("write pulse too long");
  // Mode pin goes through a synchroniser, so it must stand four cycles
  irq_strobe_a: assert property (bus_style_sel [*4] |=>
    chan_a_irq == $past(irq_req[0]) && chan_a_irq_oe_n == !$past(aux2_en[0])) else $error("irq strobe");
  irq_shared_a: assert property (!bus_style_sel [*4] |=> !chan_a_irq && chan_b_irq_oe_n &&
    chan_a_irq_oe_n == !($past(irq_req[0]) || $past(irq_req[1]))) else $error("irq shared");
  serial_a: assert property (1'b1 |=> serial_out_chan_a ==
    ($past(ir_mode[0]) ? $past(tx_ir_bit[0]) : $past(tx_bit[0]))) else $error("serial out");
  rts_dir_a: assert property (rs485_dir[0] |=> request_to_send_a_n == !$past(tx_busy[0]))
    else $error("rts direction");
endmodule
bind dubp_host_port dubp_host_port_chk chk (.*);

// ==== tb/dubp_host_model.sv ====
module dubp_host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n,
  output logic      [7:0] data_in,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic            chan_a_select_n,
  output logic            chan_b_select_n,
  output logic      [2:0] addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hd = 8'h00;
  logic [7:0] flt = 8'h55;
  logic       hen = 1'b0;
  // Released bus toggles, so a stale byte can never pass as read data
  always @(posedge clk_sys) flt <= ~flt;
  assign data_in = !data_oe_n ? data_out : hen ? hd : flt;
  initial {write_strobe_n, read_strobe_n, chan_b_select_n, chan_a_select_n, addr} = 7'h78;
  // ----------
  // Access; ch 2 lowers both selects
  // ----------
  task automatic acc(input logic md, input int ch, input logic rd, input logic [2:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_sys);
    addr = a;
    hd = d;
    hen = !rd;
    if (md) begin
      {chan_b_select_n, chan_a_select_n} = (ch == 0) ? 2'h2 : (ch == 1) ? 2'h1 : 2'h0;
      {write_strobe_n, read_strobe_n} = rd ? 2'h2 : 2'h1;
    end else begin
      {chan_b_select_n, chan_a_select_n} = {ch[0], 1'b0};
      {write_strobe_n, read_strobe_n} = {rd, 1'b0};
    end
    repeat (8) @(negedge clk_sys);
    q = data_in;
    {write_strobe_n, read_strobe_n, chan_b_select_n, chan_a_select_n} = 4'hf;
    repeat (4) @(negedge clk_sys);
    hen = 1'b0;
  endtask
endmodule

// ==== tb/dubp_host_port_bench.sv ====
module dubp_host_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rstn = 1'b0, bus_style_sel = 1'b1, reg_rd, reg_wr, reg_chan, data_oe_n;
  logic read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n;
  logic [2:0] addr, reg_addr;
  logic [7:0] data_in, data_out, reg_wdata, reg_rdata = 8'h00, q;
  logic [7:0] core [16];
  logic [1:0] irq_req, aux2_en, ir_mode, rx_invert, rts_on, auto_rts, rx_room, rs485_dir, tx_busy, auto_cts;
  logic [1:0] dtr_on, tx_bit, tx_ir_bit, tx_fifo_ready, rx_fifo_ready, si, cts, dsr, cd, ri, e_rts;
  wire [1:0] rx_data, cts_on, dsr_on, cd_on, ri_on, tx_allowed, irq, ioe, aux_n, txr, rxr, so, rts, dtr;
  int err_total = 0, checked = 0, seed = 2274, mdl [16];
  logic [31:0] r;
  dubp_host_model host (.*);
  dubp_host_port dut (.*, .chan_a_irq(irq[0]), .chan_b_irq(irq[1]), .chan_a_irq_oe_n(ioe[0]),
    .chan_b_irq_oe_n(ioe[1]), .aux_out2_chan_a_n(aux_n[0]), .aux_out2_chan_b_n(aux_n[1]),
    .tx_ready_chan_a_n(txr[0]), .tx_ready_chan_b_n(txr[1]), .rx_ready_chan_a_n(rxr[0]),
    .rx_ready_chan_b_n(rxr[1]), .serial_out_chan_a(so[0]), .serial_out_chan_b(so[1]),
    .serial_in_chan_a(si[0]), .serial_in_chan_b(si[1]), .request_to_send_a_n(rts[0]),
    .request_to_send_b_n(rts[1]), .clear_to_send_a_n(cts[0]), .clear_to_send_b_n(cts[1]),
    .terminal_ready_a_n(dtr[0]), .terminal_ready_b_n(dtr[1]), .set_ready_a_n(dsr[0]),
    .set_ready_b_n(dsr[1]), .carrier_detect_a_n(cd[0]), .carrier_detect_b_n(cd[1]),
    .ring_indicator_a_n(ri[0]), .ring_indicator_b_n(ri[1]));
  always #4 clk_sys = ~clk_sys;
  // Core register stub answers on the falling edge in the middle of the read pulse
  always @(negedge clk_sys) begin
    if (reg_wr) core[{reg_chan, reg_addr}] <= reg_wdata;
    if (reg_rd) reg_rdata <= core[{reg_chan, reg_addr}];
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic bus_test(input logic md);
    bus_style_sel = md;
    repeat (4) @(negedge clk_sys);
    for (int k = 0; k < 16; k++) begin
      mdl[k] = $random(seed) & 8'hff;
      host.acc(md, k / 8, 1'b0, k[2:0], mdl[k][7:0], q);
    end
    for (int k = 0; k < 16; k++) begin
      host.acc(md, k / 8, 1'b1, k[2:0], 8'h00, q);
      chk(q, mdl[k][7:0], "read back");
    end
    $display("bus test mode %0d done", md);
  endtask
  initial begin
    {irq_req, aux2_en, ir_mode, rx_invert, rts_on, auto_rts, rx_room, rs485_dir, tx_busy, auto_cts} = '0;
    {dtr_on, tx_bit, tx_ir_bit, tx_fifo_ready, rx_fifo_ready} = '0;
    {si, cts, dsr, cd, ri} = '1;
    repeat (10) @(negedge clk_sys);
    chk({so, data_oe_n, reg_rd, reg_wr}, 5'h1c, "reset idle");
    rstn = 1'b1;
    bus_test(1'b0);
    // Strobe mode last, so the pin is high for the both-selects case
    bus_test(1'b1);
    host.acc(1'b1, 2, 1'b0, 3'h0, ~mdl[0][7:0], q);
    host.acc(1'b1, 0, 1'b1, 3'h0, 8'h00, q);
    chk({q, data_oe_n}, {mdl[0][7:0], 1'b1}, "both selects");
    $display("select test done");
    repeat (40) begin
      @(negedge clk_sys);
      r = $random(seed);
      {irq_req, aux2_en, ir_mode, rx_invert, rts_on, auto_rts, rx_room, rs485_dir} = r[15:0];
      {tx_busy, auto_cts, dtr_on, tx_bit, tx_ir_bit, tx_fifo_ready, rx_fifo_ready, si} = r[31:16];
      r = $random(seed);
      {cts, dsr, cd, ri, bus_style_sel} = r[8:0];
      repeat (4) @(negedge clk_sys);
      e_rts = rs485_dir & ~tx_busy | ~rs485_dir & ~(rts_on & (rx_room | ~auto_rts));
      chk({txr, rxr, so, rts, dtr, aux_n}, {~tx_fifo_ready, ~rx_fifo_ready,
        ir_mode & tx_ir_bit | ~ir_mode & tx_bit, e_rts, ~dtr_on, ~aux2_en}, "outputs");
      chk({rx_data, cts_on, dsr_on, cd_on, ri_on, tx_allowed},
        {si ^ (ir_mode & rx_invert), ~cts, ~dsr, ~cd, ~ri, ~auto_cts | ~cts}, "inputs");
      chk(bus_style_sel ? {irq, ioe} : {irq[0], ioe},
        bus_style_sel ? {irq_req, ~aux2_en} : {2'h1, ~|irq_req}, "irq");
    end
    $display("pin test done");
    give_verdict;
  end
  initial begin
    #30us;
    err_total++;
    give_verdict;
  end
endmodule
